// ==== src/pwm_channel.sv ====
// One left-aligned PWM channel with an APB register interface.
`timescale 1ns/100ps

//
// Behaviour
// - A counter read returns the live count and changes nothing.
// - Any counter write clears it, sets up counting, loads buffers and sets the output.
// - With the enable bit clear the counter holds.
// - Setting the enable bit resumes counting from the held value.
// - While disabled, writing zero to the period resets the counter on the next tick.
// - A counter write while running starts a new period at once.
// - The counter returns to zero at the end of every effective period.
// - With the alignment select bit clear the output is left aligned.
// - In left-aligned mode the counter only counts up.
// - A duty match toggles the output flip-flop.
// - A period match resets the counter, sets the output from the polarity bit and loads the buffered values.
// - The count runs from zero to one less than the active period.
module pwm_channel (
   input wire logic CLK_IN, // Bus clock, 50 MHz.
   input wire logic RST_IN, // Asynchronous reset, active high.
   input wire logic PSEL_IN, // APB select.
   input wire logic PENABLE_IN, // APB access phase.
   input wire logic PWRITE_IN, // APB direction, high for write.
   input wire logic [7:0] PADDR_IN, // APB byte address.
   input wire logic [31:0] PWDATA_IN, // APB write data.
   output logic [31:0] PRDATA_OUT, // APB read data.
   output logic PREADY_OUT, // APB ready.
   output logic PSLVERR_OUT, // APB error for unmapped address.
   output logic PWM_OUT // PWM waveform.
);

   pwm_chan_pkg::ctrl_type ctrl_reg;
   pwm_chan_pkg::pair_type buf_reg;
   pwm_chan_pkg::pair_type act_reg;
   logic [7:0] prescale_reg;
   logic [7:0] count_reg;
   logic out_reg;
   logic zero_period_reg;
   logic [31:0] rdata_reg;
   logic tick;
   logic access;
   logic wr;
   logic mapped;
   logic cnt_write;
   logic duty_match;
   logic period_end;
   logic restart;

   // Tells whether an address decodes to one of the channel registers.
   function automatic logic is_mapped(input logic [7:0] addr);
      is_mapped = (addr == pwm_chan_pkg::CTRL_ADDR) || (addr == pwm_chan_pkg::PERIOD_ADDR) ||
         (addr == pwm_chan_pkg::DUTY_ADDR) || (addr == pwm_chan_pkg::COUNTER_ADDR) ||
         (addr == pwm_chan_pkg::STATUS_ADDR) || (addr == pwm_chan_pkg::PRESCALE_ADDR);
   endfunction

   // Output level at the start of a period, taken from the polarity bit.
   function automatic logic start_level(input logic pol);
      start_level = pol;
   endfunction

   // Channel clock enable from the prescaler.
   pwm_tick_divider u_div (
      .CLK_IN(CLK_IN),
      .RST_IN(RST_IN),
      .DIV_IN(prescale_reg),
      .TICK_OUT(tick)
   );

   // The slave answers in the first access cycle, so every access takes two cycles.
   assign access = PSEL_IN && PENABLE_IN;
   assign wr = access && PWRITE_IN;
   assign mapped = is_mapped(PADDR_IN);
   assign PREADY_OUT = 1'b1;
   assign PSLVERR_OUT = access && !mapped;
   assign cnt_write = wr && (PADDR_IN == pwm_chan_pkg::COUNTER_ADDR);

   // Compare logic for the left-aligned counter.
   assign duty_match = (count_reg == act_reg.duty);
   assign period_end = (count_reg + pwm_chan_pkg::COUNT_ONE >= act_reg.period);
   assign restart = ctrl_reg.enable && tick && period_end;

   // Control bits written by software.
   always_ff @(posedge CLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         ctrl_reg <= '0;
      end else if (wr && PADDR_IN == pwm_chan_pkg::CTRL_ADDR) begin
         ctrl_reg.enable <= PWDATA_IN[pwm_chan_pkg::ENABLE_BIT];
         ctrl_reg.polarity <= PWDATA_IN[pwm_chan_pkg::POLARITY_BIT];
         ctrl_reg.center_align <= PWDATA_IN[pwm_chan_pkg::ALIGN_BIT];
      end
   end

   // Prescaler setting.
   always_ff @(posedge CLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         prescale_reg <= pwm_chan_pkg::PRESCALE_RESET;
      end else if (wr && PADDR_IN == pwm_chan_pkg::PRESCALE_ADDR) begin
         prescale_reg <= PWDATA_IN[7:0];
      end
   end

   // Buffered period and duty, written by software at any time.
   always_ff @(posedge CLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         buf_reg.period <= pwm_chan_pkg::PERIOD_RESET;
         buf_reg.duty <= pwm_chan_pkg::DUTY_RESET;
      end else if (wr && PADDR_IN == pwm_chan_pkg::PERIOD_ADDR) begin
         buf_reg.period <= PWDATA_IN[7:0];
      end else if (wr && PADDR_IN == pwm_chan_pkg::DUTY_ADDR) begin
         buf_reg.duty <= PWDATA_IN[7:0];
      end
   end

   // Remembers a zero period written while disabled until the next channel tick.
   always_ff @(posedge CLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         zero_period_reg <= 1'b0;
      end else if (wr && PADDR_IN == pwm_chan_pkg::PERIOD_ADDR && !ctrl_reg.enable &&
         PWDATA_IN[7:0] == pwm_chan_pkg::COUNT_RESET) begin
         zero_period_reg <= 1'b1;
      end else if (tick || cnt_write) begin
         zero_period_reg <= 1'b0;
      end
   end

   // Active period and duty load from the buffers on a counter write or period end.
   always_ff @(posedge CLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         act_reg.period <= pwm_chan_pkg::PERIOD_RESET;
         act_reg.duty <= pwm_chan_pkg::DUTY_RESET;
      end else if (cnt_write || restart) begin
         act_reg <= buf_reg;
      end
   end

   // Channel counter: clears on write or period end, holds while disabled, else counts up.
   always_ff @(posedge CLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         count_reg <= pwm_chan_pkg::COUNT_RESET;
      end else if (cnt_write) begin
         count_reg <= pwm_chan_pkg::COUNT_RESET;
      end else if (zero_period_reg && tick) begin
         count_reg <= pwm_chan_pkg::COUNT_RESET;
      end else if (restart) begin
         count_reg <= pwm_chan_pkg::COUNT_RESET;
      end else if (ctrl_reg.enable && tick) begin
         count_reg <= count_reg + pwm_chan_pkg::COUNT_ONE;
      end
   end

   // Output flip-flop: set by polarity at a new period, toggled on duty match.
   always_ff @(posedge CLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         out_reg <= 1'b0;
      end else if (cnt_write || restart) begin
         out_reg <= start_level(ctrl_reg.polarity);
      end else if (ctrl_reg.enable && tick && duty_match) begin
         out_reg <= !out_reg;
      end
   end

   // Read data is registered in the setup phase; reads have no side effects.
   always_ff @(posedge CLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         rdata_reg <= '0;
      end else if (PSEL_IN && !PENABLE_IN && !PWRITE_IN) begin
         rdata_reg <= '0;
         unique case (PADDR_IN)
            pwm_chan_pkg::CTRL_ADDR: begin
               rdata_reg[pwm_chan_pkg::ENABLE_BIT] <= ctrl_reg.enable;
               rdata_reg[pwm_chan_pkg::POLARITY_BIT] <= ctrl_reg.polarity;
               rdata_reg[pwm_chan_pkg::ALIGN_BIT] <= ctrl_reg.center_align;
            end
            pwm_chan_pkg::PERIOD_ADDR: begin
               rdata_reg[7:0] <= buf_reg.period;
            end
            pwm_chan_pkg::DUTY_ADDR: begin
               rdata_reg[7:0] <= buf_reg.duty;
            end
            pwm_chan_pkg::COUNTER_ADDR: begin
               rdata_reg[7:0] <= count_reg;
            end
            pwm_chan_pkg::STATUS_ADDR: begin
               rdata_reg[pwm_chan_pkg::STAT_OUT_BIT] <= out_reg;
               rdata_reg[pwm_chan_pkg::STAT_RUN_BIT] <= ctrl_reg.enable;
            end
            pwm_chan_pkg::PRESCALE_ADDR: begin
               rdata_reg[7:0] <= prescale_reg;
            end
            default: begin
               rdata_reg <= '0;
            end
         endcase
      end
   end

   assign PRDATA_OUT = rdata_reg;

   // Left-aligned output only; the alignment bit is stored but center mode is absent.
   assign PWM_OUT = out_reg;

endmodule

// ==== src/pwm_chan_pkg.sv ====
// Package with register offsets, field positions, reset values and carriers for the PWM channel.
package pwm_chan_pkg;

   // Byte addresses of the channel registers on the APB bus.
   localparam logic [7:0] CTRL_ADDR = 8'h00;
   localparam logic [7:0] PERIOD_ADDR = 8'h04;
   localparam logic [7:0] DUTY_ADDR = 8'h08;
   localparam logic [7:0] COUNTER_ADDR = 8'h0c;
   localparam logic [7:0] STATUS_ADDR = 8'h10;
   localparam logic [7:0] PRESCALE_ADDR = 8'h14;

   // Control register field positions.
   localparam int ENABLE_BIT = 0;
   localparam int POLARITY_BIT = 1;
   localparam int ALIGN_BIT = 2;

   // Status register field positions.
   localparam int STAT_OUT_BIT = 0;
   localparam int STAT_RUN_BIT = 1;

   // Reset values and the counter step.
   localparam logic [7:0] PERIOD_RESET = 8'hff;
   localparam logic [7:0] DUTY_RESET = 8'hff;
   localparam logic [7:0] COUNT_RESET = 8'h00;
   localparam logic [7:0] PRESCALE_RESET = 8'h00;
   localparam logic [7:0] COUNT_ONE = 8'h01;

   // Width of the register file and of the channel data.
   localparam int DATA_W = 8;

   // Software settings for the channel, carried as one group.
   typedef struct packed {
      logic enable;
      logic polarity;
      logic center_align;
   } ctrl_type;

   // Double-buffered values, used both for buffers and active registers.
   typedef struct packed {
      logic [7:0] period;
      logic [7:0] duty;
   } pair_type;

endpackage

// ==== src/pwm_tick_divider.sv ====
// Prescaler that makes the one-cycle channel clock enable from the bus clock.
`timescale 1ns/100ps
module pwm_tick_divider (
   input wire logic CLK_IN, // Bus clock.
   input wire logic RST_IN, // Asynchronous reset, active high.
   input wire logic [7:0] DIV_IN, // Divide value minus one.
   output logic TICK_OUT // One-cycle pulse at the channel rate.
);

   logic [7:0] cnt_reg;

   // Counts down from the divide value minus one and pulses when it wraps.
   always_ff @(posedge CLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         cnt_reg <= pwm_chan_pkg::COUNT_RESET;
      end else if (cnt_reg == pwm_chan_pkg::COUNT_RESET) begin
         cnt_reg <= DIV_IN;
      end else begin
         cnt_reg <= cnt_reg - pwm_chan_pkg::COUNT_ONE;
      end
   end

   // The tick is the wrap of the counter.
   assign TICK_OUT = (cnt_reg == pwm_chan_pkg::COUNT_RESET);

endmodule

// ==== tb/pwm_channel_props.sv ====
// Checker with concurrent assertions on the PWM channel ports.
`timescale 1ns/100ps
module pwm_channel_props (
   input wire logic CLK_IN, // Bus clock.
   input wire logic RST_IN, // Reset.
   input wire logic PSEL_IN, // Select.
   input wire logic PENABLE_IN, // Access phase.
   input wire logic PWRITE_IN, // Direction.
   input wire logic [7:0] PADDR_IN, // Address.
   input wire logic [31:0] PWDATA_IN, // Write data.
   input wire logic [31:0] PRDATA_OUT, // Read data.
   input wire logic PREADY_OUT, // Ready.
   input wire logic PSLVERR_OUT, // Error.
   input wire logic PWM_OUT // Waveform.
);
   logic [2:0] ctrl_reg;
   logic acc;
   logic wr;
   logic rd;
   logic mapped;
   default clocking @(posedge CLK_IN); endclocking
   default disable iff (RST_IN);
   // Completed transfers and the address decode as seen on the bus.
   assign acc = PSEL_IN && PENABLE_IN && PREADY_OUT;
   assign wr = acc && PWRITE_IN;
   assign rd = acc && !PWRITE_IN;
   assign mapped = PADDR_IN[1:0] == 2'h0 && PADDR_IN <= pwm_chan_pkg::PRESCALE_ADDR;
   // Shadow of the control bits, so outputs can be tied to their settings.
   always_ff @(posedge CLK_IN or posedge RST_IN) begin
      if (RST_IN) ctrl_reg <= 3'h0;
      else if (wr && PADDR_IN == pwm_chan_pkg::CTRL_ADDR) ctrl_reg <= PWDATA_IN[2:0];
   end
   a_ready_high: assert property (PREADY_OUT) else $error("ready low");
   a_err_unmapped: assert property (PSEL_IN && PENABLE_IN && !mapped |-> PSLVERR_OUT)
      else $error("no error on unmapped address");
   a_err_mapped: assert property (mapped |-> !PSLVERR_OUT) else $error("error on mapped address");
   a_err_rdata: assert property (rd && !mapped |-> PRDATA_OUT == 32'h0)
      else $error("unmapped read data not zero");
   a_upper_zero: assert property (rd |-> PRDATA_OUT[31:8] == 24'h0) else $error("upper bits set");
   a_ctrl_readback: assert property (rd && PADDR_IN == pwm_chan_pkg::CTRL_ADDR
      |-> PRDATA_OUT[2:0] == ctrl_reg) else $error("control readback wrong");
   a_status_view: assert property (rd && PADDR_IN == pwm_chan_pkg::STATUS_ADDR
      |-> PRDATA_OUT[1:0] == {ctrl_reg[0], $past(PWM_OUT)}) else $error("status wrong");
   a_pol_clear: assert property (wr && PADDR_IN == pwm_chan_pkg::COUNTER_ADDR
      |=> PWM_OUT == ctrl_reg[1]) else $error("output not set from polarity");
   a_hold_off: assert property (!ctrl_reg[0] && !$past(wr) |-> $stable(PWM_OUT))
      else $error("output moved while disabled");
endmodule

// ==== tb/tb_top.sv ====
// Self-checking bench for the PWM channel, driven over APB.
`timescale 1ns/100ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin bad_count++; \
   $display("unexpected %s exp %h got %h", n, e, g); end end
module tb_top;
   logic CLK_IN = 1'b0;
   logic RST_IN = 1'b1;
   logic PSEL_IN = 1'b0;
   logic PENABLE_IN = 1'b0;
   logic PWRITE_IN = 1'b0;
   logic [7:0] PADDR_IN = 8'h00;
   logic [31:0] PWDATA_IN = 32'h0;
   logic [31:0] PRDATA_OUT;
   logic PREADY_OUT;
   logic PSLVERR_OUT;
   logic PWM_OUT;
   logic [31:0] rd_data;
   logic [31:0] held;
   logic err;
   logic prev;
   int bad_count = 0;
   int checked = 0;
   int highs;
   int rises;
   pwm_channel u_dut (.CLK_IN(CLK_IN), .RST_IN(RST_IN), .PSEL_IN(PSEL_IN),
      .PENABLE_IN(PENABLE_IN), .PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN),
      .PWDATA_IN(PWDATA_IN), .PRDATA_OUT(PRDATA_OUT), .PREADY_OUT(PREADY_OUT),
      .PSLVERR_OUT(PSLVERR_OUT), .PWM_OUT(PWM_OUT));
   // Bus clock at 50 MHz.
   initial begin
      forever #10 CLK_IN = ~CLK_IN;
   end
   // Prints the counts and the verdict, then ends the run.
   task automatic final_report();
      $display("comparisons %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // One APB transfer; waits for ready under a bound, then idles one cycle.
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      PSEL_IN <= 1'b1;
      PWRITE_IN <= w;
      PADDR_IN <= a;
      PWDATA_IN <= d;
      @(posedge CLK_IN);
      PENABLE_IN <= 1'b1;
      @(posedge CLK_IN);
      while (PREADY_OUT !== 1'b1) begin
         n++;
         if (n > 20) begin
            bad_count++;
            final_report();
         end
         @(posedge CLK_IN);
      end
      rd_data = PRDATA_OUT;
      err = PSLVERR_OUT;
      PSEL_IN <= 1'b0;
      PENABLE_IN <= 1'b0;
      @(posedge CLK_IN);
   endtask
   // Read with comparison against an expected word.
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input string n);
      xfer(1'b0, a, 32'h0);
      `CHK(n, e, rd_data)
   endtask
   // Main sequence.
   initial begin
      repeat (6) @(posedge CLK_IN);
      RST_IN <= 1'b0;
      @(posedge CLK_IN);
      rd(pwm_chan_pkg::CTRL_ADDR, 32'h0, "ctrl");
      rd(pwm_chan_pkg::PERIOD_ADDR, 32'hff, "period");
      rd(pwm_chan_pkg::DUTY_ADDR, 32'hff, "duty");
      rd(pwm_chan_pkg::COUNTER_ADDR, 32'h0, "count");
      rd(8'h40, 32'h0, "unmapped");
      `CHK("slverr", 1'b1, err)
      xfer(1'b1, pwm_chan_pkg::PRESCALE_ADDR, 32'h3);
      rd(pwm_chan_pkg::PRESCALE_ADDR, 32'h3, "prescale");
      xfer(1'b1, pwm_chan_pkg::PRESCALE_ADDR, 32'h0);
      $display("test registers done");
      // Period 8, duty 1, both polarities: measure four whole periods.
      for (int p = 0; p < 2; p++) begin
         xfer(1'b1, pwm_chan_pkg::PERIOD_ADDR, 32'h8);
         xfer(1'b1, pwm_chan_pkg::DUTY_ADDR, 32'h1);
         xfer(1'b1, pwm_chan_pkg::CTRL_ADDR, 32'(2 * p));
         xfer(1'b1, pwm_chan_pkg::COUNTER_ADDR, 32'h5a);
         `CHK("out after clear", p[0], PWM_OUT)
         rd(pwm_chan_pkg::COUNTER_ADDR, 32'h0, "cleared");
         xfer(1'b1, pwm_chan_pkg::CTRL_ADDR, 32'(2 * p + 1));
         highs = 0;
         rises = 0;
         prev = PWM_OUT;
         repeat (32) begin
            @(posedge CLK_IN);
            highs += int'(PWM_OUT);
            rises += int'(PWM_OUT && !prev);
            prev = PWM_OUT;
         end
         `CHK("high cycles", (p == 1) ? 8 : 24, highs)
         `CHK("periods", 4, rises)
      end
      repeat (6) begin
         xfer(1'b0, pwm_chan_pkg::COUNTER_ADDR, 32'h0);
         `CHK("count range", 1'b1, rd_data < 32'h8)
      end
      xfer(1'b1, pwm_chan_pkg::COUNTER_ADDR, 32'h0);
      `CHK("restart level", 1'b1, PWM_OUT)
      $display("test waveform done");
      // Stop, hold, resume, then a zero period while stopped.
      xfer(1'b1, pwm_chan_pkg::CTRL_ADDR, 32'h2);
      xfer(1'b0, pwm_chan_pkg::COUNTER_ADDR, 32'h0);
      held = rd_data;
      repeat (5) @(posedge CLK_IN);
      rd(pwm_chan_pkg::COUNTER_ADDR, held, "held");
      xfer(1'b1, pwm_chan_pkg::CTRL_ADDR, 32'h3);
      xfer(1'b0, pwm_chan_pkg::COUNTER_ADDR, 32'h0);
      `CHK("resumed", 1'b1, rd_data != held)
      xfer(1'b1, pwm_chan_pkg::CTRL_ADDR, 32'h2);
      xfer(1'b1, pwm_chan_pkg::PERIOD_ADDR, 32'h0);
      rd(pwm_chan_pkg::COUNTER_ADDR, 32'h0, "zero period");
      xfer(1'b1, pwm_chan_pkg::COUNTER_ADDR, 32'h0);
      rd(pwm_chan_pkg::STATUS_ADDR, 32'h1, "status");
      $display("test enable done");
      final_report();
   end
endmodule
bind pwm_channel pwm_channel_props u_props (.CLK_IN(CLK_IN), .RST_IN(RST_IN),
   .PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN), .PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN),
   .PWDATA_IN(PWDATA_IN), .PRDATA_OUT(PRDATA_OUT), .PREADY_OUT(PREADY_OUT),
   .PSLVERR_OUT(PSLVERR_OUT), .PWM_OUT(PWM_OUT));
